// [design/vim_axil.v]
// AXI4-Lite slave front end for the interruption monitor registers
`include "vim_defs.vh"

module vim_axil (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Write address and data channels
   input wire [`VIM_ADDR_W-1:0] s_awaddr,
   input wire s_awvalid,
   output reg s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output reg s_wready,
   // Write response channel
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   // Read channels
   input wire [`VIM_ADDR_W-1:0] s_araddr,
   input wire s_arvalid,
   output reg s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready,
   // Register side
   output reg wr_en,
   output reg [`VIM_ADDR_W-1:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   input wire wr_err,
   output reg [`VIM_ADDR_W-1:0] rd_addr,
   input wire [31:0] rd_data,
   input wire rd_err
);

   reg aw_have_r;
   reg w_have_r;
   reg rd_pend_r;

   // ---------------------------------------------------------------
   // Write path: address and data taken in either order
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= `VIM_RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= {`VIM_ADDR_W{1'b0}};
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
      end else begin
         wr_en <= 1'b0;
         s_awready <= !aw_have_r && !(s_awvalid && s_awready) && !s_bvalid;
         s_wready <= !w_have_r && !(s_wvalid && s_wready) && !s_bvalid;
         if (s_awvalid && s_awready) begin
            aw_have_r <= 1'b1;
            wr_addr <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_have_r <= 1'b1;
            wr_data <= s_wdata;
            wr_strb <= s_wstrb;
            s_wready <= 1'b0;
         end
         // Commit one cycle after both halves are held
         if (aw_have_r && w_have_r && !s_bvalid) begin
            wr_en <= 1'b1;
            s_bvalid <= 1'b1;
            s_bresp <= wr_err ? `VIM_RESP_SLVERR : `VIM_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
         if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read path: address held, data sampled one cycle later
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `VIM_RESP_OKAY;
         rd_pend_r <= 1'b0;
         rd_addr <= {`VIM_ADDR_W{1'b0}};
      end else begin
         s_arready <= !rd_pend_r && !s_rvalid && !(s_arvalid && s_arready);
         if (s_arvalid && s_arready) begin
            rd_addr <= s_araddr;
            rd_pend_r <= 1'b1;
            s_arready <= 1'b0;
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_err ? 32'h0 : rd_data;
            s_rresp <= rd_err ? `VIM_RESP_SLVERR : `VIM_RESP_OKAY;
         end
         if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
      end
   end

endmodule

// [design/vim_period.v]
// Calendar period boundary detector driven by the real-time clock fields
`include "vim_defs.vh"

module vim_period (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Selected period and calendar time
   input wire [2:0] period_sel,
   input wire [4:0] cal_hour,
   input wire [4:0] cal_mday,
   input wire [2:0] cal_wday,
   input wire [3:0] cal_month,
   // One-cycle boundary pulse
   output reg boundary
);

   reg seeded_r;
   reg [4:0] hour_r;
   reg [4:0] mday_r;
   reg [3:0] month_r;
   reg hit;
   wire hour_chg;
   wire day_chg;
   wire mon_chg;

   // Nothing is compared until one snapshot exists, else reset fakes one
   assign hour_chg = seeded_r && (hour_r != cal_hour);
   assign day_chg = seeded_r && (mday_r != cal_mday);
   assign mon_chg = seeded_r && (month_r != cal_month);

   always @* begin
      case (period_sel)
         `VIM_PER_8H: hit = hour_chg && (cal_hour == `VIM_HOUR_0 ||
            cal_hour == `VIM_HOUR_8 || cal_hour == `VIM_HOUR_16);
         `VIM_PER_DAY: hit = day_chg;
         `VIM_PER_WEEK: hit = day_chg && (cal_wday == `VIM_MONDAY);
         `VIM_PER_MONTH: hit = mon_chg;
         `VIM_PER_YEAR: hit = mon_chg && (cal_month == `VIM_JANUARY);
         default: hit = 1'b0;
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         seeded_r <= 1'b0;
         hour_r <= 5'h0;
         mday_r <= 5'h0;
         month_r <= 4'h0;
         boundary <= 1'b0;
      end else begin
         seeded_r <= 1'b1;
         hour_r <= cal_hour;
         mday_r <= cal_mday;
         month_r <= cal_month;
         boundary <= hit;
      end
   end

endmodule

// [design/vim_top.v]
// Voltage interruption monitor: detection, accumulation and registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "vim_defs.vh"

module vim_top #(
   parameter TICK_CYC = `VIM_TICK_NS / `VIM_CLK_NS,
   parameter TICK_W = 18
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Positive sequence voltage in tenths of a percent
   input wire meas_valid,
   input wire [`VIM_LIM_W-1:0] positive_seq_voltage,
   // Calendar time from the real-time clock
   input wire [4:0] cal_hour,
   input wire [4:0] cal_mday,
   input wire [2:0] cal_wday,
   input wire [3:0] cal_month,
   // AXI4-Lite write channels
   input wire [`VIM_ADDR_W-1:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   output wire [1:0] s_bresp,
   output wire s_bvalid,
   input wire s_bready,
   // AXI4-Lite read channels
   input wire [`VIM_ADDR_W-1:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output wire [31:0] s_rdata,
   output wire [1:0] s_rresp,
   output wire s_rvalid,
   input wire s_rready,
   // Status outputs
   output reg voltage_low,
   output reg irq
);

   localparam [31:0] TICK_LAST_FULL = TICK_CYC - 1;
   localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_FULL[TICK_W-1:0];

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function [31:0] sat_inc;
      input [31:0] val;
      begin
         sat_inc = (&val) ? val : val + 32'h1;
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   function mapped;
      input [`VIM_ADDR_W-1:0] a;
      begin
         case (a)
            `VIM_REG_LIMIT, `VIM_REG_PERIOD, `VIM_REG_STATUS,
            `VIM_REG_VOLT, `VIM_REG_COUNT, `VIM_REG_PREV_COUNT,
            `VIM_REG_TOTAL, `VIM_REG_PREV_TOTAL, `VIM_REG_IRQ_STAT,
            `VIM_REG_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   wire wr_en;
   wire [`VIM_ADDR_W-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [`VIM_ADDR_W-1:0] rd_addr;
   wire boundary;
   reg [31:0] rd_data;
   reg [31:0] wr_word;
   reg [`VIM_LIM_W-1:0] limit_r;
   reg [2:0] period_r;
   reg [`VIM_LIM_W-1:0] volt_r;
   reg low_r;
   reg [31:0] count_r;
   reg [31:0] prev_count_r;
   reg [31:0] total_r;
   reg [31:0] prev_total_r;
   reg [9:0] ms_r;
   reg [TICK_W-1:0] tick_cnt_r;
   reg tick_r;
   reg [`VIM_IRQ_W-1:0] irq_stat_r;
   reg [`VIM_IRQ_W-1:0] irq_mask_r;
   reg [`VIM_IRQ_W-1:0] irq_set;
   reg [`VIM_IRQ_W-1:0] irq_stat_nxt;
   wire below;
   wire dip_start;
   wire recover;

   // ---------------------------------------------------------------
   // Bus slave and period detector
   // ---------------------------------------------------------------
   vim_axil u_axil (
      .mclk(mclk),
      .rst(rst),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(!mapped(wr_addr)),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(!mapped(rd_addr))
   );

   vim_period u_period (
      .mclk(mclk),
      .rst(rst),
      .period_sel(period_r),
      .cal_hour(cal_hour),
      .cal_mday(cal_mday),
      .cal_wday(cal_wday),
      .cal_month(cal_month),
      .boundary(boundary)
   );

   // ---------------------------------------------------------------
   // Settings
   // ---------------------------------------------------------------
   always @* begin
      wr_word = 32'h0;
      case (wr_addr)
         `VIM_REG_LIMIT: wr_word = merge({21'h0, limit_r}, wr_data, wr_strb);
         `VIM_REG_PERIOD: wr_word = merge({29'h0, period_r}, wr_data, wr_strb);
         `VIM_REG_IRQ_MASK:
            wr_word = merge({29'h0, irq_mask_r}, wr_data, wr_strb);
         default: wr_word = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
            {8{wr_strb[1]}}, {8{wr_strb[0]}}};
      endcase
   end

   // Out-of-range limit and period values are dropped so the setting never leaves its range
   always @(posedge mclk) begin
      if (rst) begin
         limit_r <= `VIM_LIMIT_RST;
         period_r <= `VIM_PER_MONTH;
         irq_mask_r <= {`VIM_IRQ_W{1'b0}};
      end else if (wr_en) begin
         if (wr_addr == `VIM_REG_LIMIT && wr_word[31:`VIM_LIM_W] == 21'h0 &&
             wr_word[`VIM_LIM_W-1:0] >= `VIM_LIMIT_MIN &&
             wr_word[`VIM_LIM_W-1:0] <= `VIM_LIMIT_MAX)
            limit_r <= wr_word[`VIM_LIM_W-1:0];
         if (wr_addr == `VIM_REG_PERIOD && wr_word[31:3] == 29'h0 &&
             wr_word[2:0] <= `VIM_PER_YEAR)
            period_r <= wr_word[2:0];
         if (wr_addr == `VIM_REG_IRQ_MASK)
            irq_mask_r <= wr_word[`VIM_IRQ_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Interruption detection
   // ---------------------------------------------------------------
   // every sample compared
   assign below = positive_seq_voltage < limit_r;
   assign dip_start = meas_valid && below && !low_r;
   assign recover = meas_valid && !below && low_r;

   always @(posedge mclk) begin
      if (rst) begin
         volt_r <= {`VIM_LIM_W{1'b0}};
         low_r <= 1'b0;
         voltage_low <= 1'b0;
      end else begin
         if (meas_valid) begin
            volt_r <= positive_seq_voltage;
            low_r <= below;
            voltage_low <= below;
         end
      end
   end

   // ---------------------------------------------------------------
   // Millisecond tick
   // ---------------------------------------------------------------
   // fixed tick divider
   always @(posedge mclk) begin
      if (rst) begin
         tick_cnt_r <= {TICK_W{1'b0}};
         tick_r <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == TICK_LAST);
         if (tick_cnt_r == TICK_LAST)
            tick_cnt_r <= {TICK_W{1'b0}};
         else
            tick_cnt_r <= tick_cnt_r + {{(TICK_W-1){1'b0}}, 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // Count and time accumulation
   // ---------------------------------------------------------------
   // A dip still running at a boundary keeps timing into the new period
   always @(posedge mclk) begin
      if (rst) begin
         count_r <= 32'h0;
         prev_count_r <= 32'h0;
         total_r <= 32'h0;
         prev_total_r <= 32'h0;
         ms_r <= 10'h0;
      end else begin
         if (boundary) begin
            prev_count_r <= count_r;
            prev_total_r <= total_r;
         end
         if (dip_start)
            count_r <= boundary ? 32'h1 : sat_inc(count_r);
         else if (boundary)
            count_r <= 32'h0;
         if (boundary) begin
            total_r <= 32'h0;
            ms_r <= 10'h0;
         end else if (tick_r && low_r) begin
            if (ms_r == `VIM_MS_LAST) begin
               ms_r <= 10'h0;
               total_r <= sat_inc(total_r);
            end else begin
               ms_r <= ms_r + 10'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupts: set wins over a same-cycle clear
   // ---------------------------------------------------------------
   always @* begin
      irq_set = {`VIM_IRQ_W{1'b0}};
      irq_set[`VIM_IRQ_START] = dip_start;
      irq_set[`VIM_IRQ_BOUND] = boundary;
      irq_set[`VIM_IRQ_RESTORE] = recover;
      irq_stat_nxt = irq_stat_r;
      if (wr_en && wr_addr == `VIM_REG_IRQ_STAT)
         irq_stat_nxt = irq_stat_r & ~(wr_data[`VIM_IRQ_W-1:0] &
            {`VIM_IRQ_W{wr_strb[0]}});
      irq_stat_nxt = irq_stat_nxt | irq_set;
   end

   always @(posedge mclk) begin
      if (rst) begin
         irq_stat_r <= {`VIM_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------
   always @* begin
      case (rd_addr)
         `VIM_REG_LIMIT: rd_data = {21'h0, limit_r};
         `VIM_REG_PERIOD: rd_data = {29'h0, period_r};
         `VIM_REG_STATUS: rd_data = {31'h0, low_r};
         `VIM_REG_VOLT: rd_data = {21'h0, volt_r};
         `VIM_REG_COUNT: rd_data = count_r;
         `VIM_REG_PREV_COUNT: rd_data = prev_count_r;
         `VIM_REG_TOTAL: rd_data = total_r;
         `VIM_REG_PREV_TOTAL: rd_data = prev_total_r;
         `VIM_REG_IRQ_STAT: rd_data = {29'h0, irq_stat_r};
         `VIM_REG_IRQ_MASK: rd_data = {29'h0, irq_mask_r};
         default: rd_data = 32'h0;
      endcase
   end

endmodule

// [inc/vim_defs.vh]
// Constants shared by the voltage interruption monitor files
`ifndef VIM_DEFS_VH
`define VIM_DEFS_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define VIM_ADDR_W 8
`define VIM_REG_LIMIT 8'h00
`define VIM_REG_PERIOD 8'h04
`define VIM_REG_STATUS 8'h08
`define VIM_REG_VOLT 8'h0c
`define VIM_REG_COUNT 8'h10
`define VIM_REG_PREV_COUNT 8'h14
`define VIM_REG_TOTAL 8'h18
`define VIM_REG_PREV_TOTAL 8'h1c
`define VIM_REG_IRQ_STAT 8'h20
`define VIM_REG_IRQ_MASK 8'h24

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define VIM_RESP_OKAY 2'h0
`define VIM_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// Limit in tenths of a percent, period codes
// ---------------------------------------------------------------
`define VIM_LIM_W 11
`define VIM_LIMIT_MIN 11'h064
`define VIM_LIMIT_MAX 11'h4b0
`define VIM_LIMIT_RST 11'h280
`define VIM_PER_8H 3'h0
`define VIM_PER_DAY 3'h1
`define VIM_PER_WEEK 3'h2
`define VIM_PER_MONTH 3'h3
`define VIM_PER_YEAR 3'h4

// ---------------------------------------------------------------
// Calendar markers
// ---------------------------------------------------------------
`define VIM_HOUR_0 5'h00
`define VIM_HOUR_8 5'h08
`define VIM_HOUR_16 5'h10
`define VIM_MONDAY 3'h1
`define VIM_JANUARY 4'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define VIM_CLK_NS 4
`define VIM_TICK_NS 1000000
`define VIM_MS_LAST 10'h3e7

// ---------------------------------------------------------------
// Interrupt bits
// ---------------------------------------------------------------
`define VIM_IRQ_W 3
`define VIM_IRQ_START 0
`define VIM_IRQ_BOUND 1
`define VIM_IRQ_RESTORE 2

`endif

// [tb/tb_voltage_interruption_monitor.sv]
// Self-checking bench for the voltage interruption monitor
`include "vim_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_voltage_interruption_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   // Short tick keeps one second at 2000 cycles
   localparam TICK = 2;
   logic mclk = 0, rst = 1, meas_valid = 0;
   logic [10:0] volt = 11'h000;
   logic [4:0] hour = 5'h05, mday = 5'h0a;
   logic [2:0] wday = 3'h3;
   logic [3:0] month = 4'h6;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, vlow, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int bad_count = 0, check_count = 0, exp_cnt = 0, exp_tot = 0;

   vim_top #(.TICK_CYC(TICK), .TICK_W(18)) dut (
      .mclk(mclk), .rst(rst), .meas_valid(meas_valid),
      .positive_seq_voltage(volt), .cal_hour(hour), .cal_mday(mday),
      .cal_wday(wday), .cal_month(month), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
      .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready), .voltage_low(vlow), .irq(irq)
   );

   initial begin
      forever #2 mclk = ~mclk;
   end

   // -----------------------------------------------------------
   // Bus and stimulus tasks
   // -----------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta;
      logic tw;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Each channel is released only at its own handshake edge
      do begin
         @(negedge mclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while ((awvalid & !ta) | (wvalid & !tw));
      // Only the watchdog ends a wait for the answer
      @(negedge mclk);
      while (!bvalid) @(negedge mclk);
      rs = bresp;
      @(posedge mclk);
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge mclk);
      while (!arready) @(negedge mclk);
      @(posedge mclk);
      arvalid <= 1'b0;
      @(negedge mclk);
      while (!rvalid) @(negedge mclk);
      rd = rdata;
      rs = rresp;
      @(posedge mclk);
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
      rdr(a);
      `CHK(nm, e, rd)
      `CHK("rresp", `VIM_RESP_OKAY, rs)
   endtask

   task automatic smp(input logic [10:0] v);
      @(posedge mclk);
      meas_valid <= 1'b1;
      volt <= v;
      @(posedge mclk);
      meas_valid <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic dip;
      smp(11'h032);
      exp_cnt++;
      smp(11'h4b0);
   endtask

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset;
      rchk(`VIM_REG_LIMIT, 32'h280, "limit");
      rchk(`VIM_REG_PERIOD, 32'h3, "period");
      rchk(`VIM_REG_COUNT, 32'h0, "count");
      rchk(`VIM_REG_IRQ_MASK, 32'h0, "mask");
      rdr(8'h40);
      `CHK("rd err", `VIM_RESP_SLVERR, rs)
      `CHK("rd err data", 32'h0, rd)
      wr(8'h40, 32'h1);
      `CHK("wr err", `VIM_RESP_SLVERR, rs)
      $display("test reset done");
   endtask

   task automatic t_limit;
      logic [31:0] lv [5] = '{32'h63, 32'h4b1, 32'h64, 32'h4b0, 32'h280};
      logic [31:0] le [5] = '{32'h280, 32'h280, 32'h64, 32'h4b0, 32'h280};
      for (int i = 0; i < 5; i++) begin
         wr(`VIM_REG_LIMIT, lv[i]);
         rchk(`VIM_REG_LIMIT, le[i], "limit");
      end
      wr(`VIM_REG_PERIOD, 32'h5);
      rchk(`VIM_REG_PERIOD, 32'h3, "period");
      $display("test limit done");
   endtask

   task automatic t_dip;
      wr(`VIM_REG_IRQ_MASK, 32'h1);
      smp(11'h27f);
      exp_cnt++;
      `CHK("low", 1'b1, vlow)
      `CHK("irq", 1'b1, irq)
      rchk(`VIM_REG_STATUS, 32'h1, "status");
      rchk(`VIM_REG_VOLT, 32'h27f, "volt");
      wr(`VIM_REG_IRQ_MASK, 32'h0);
      // The mask lands one edge after the answer edge, irq follows one edge later
      repeat (2) @(negedge mclk);
      `CHK("irq masked", 1'b0, irq)
      smp(11'h27f);
      rchk(`VIM_REG_COUNT, exp_cnt, "count");
      repeat (1000 * TICK + 100) @(posedge mclk);
      exp_tot = 1;
      rchk(`VIM_REG_TOTAL, exp_tot, "total");
      // Equal to the limit is not an interruption
      smp(11'h280);
      `CHK("ok", 1'b0, vlow)
      repeat (1000 * TICK) @(posedge mclk);
      rchk(`VIM_REG_TOTAL, exp_tot, "total");
      rchk(`VIM_REG_IRQ_STAT, 32'h5, "irq stat");
      wr(`VIM_REG_IRQ_STAT, 32'h7);
      rchk(`VIM_REG_IRQ_STAT, 32'h0, "irq clr");
      wr(`VIM_REG_IRQ_MASK, 32'h7);
      @(negedge mclk);
      `CHK("irq clr", 1'b0, irq)
      $display("test dip done");
   endtask

   task automatic t_period;
      // Per code: a change that is no boundary, then one that is
      logic [16:0] st [10] = '{
         {5'h07, 5'h0a, 3'h3, 4'h6}, {5'h08, 5'h0a, 3'h3, 4'h6},
         {5'h17, 5'h0a, 3'h3, 4'h6}, {5'h17, 5'h0b, 3'h3, 4'h6},
         {5'h17, 5'h0c, 3'h4, 4'h6}, {5'h17, 5'h0d, 3'h1, 4'h6},
         {5'h17, 5'h0e, 3'h2, 4'h6}, {5'h17, 5'h0e, 3'h2, 4'h7},
         {5'h17, 5'h0e, 3'h2, 4'h8}, {5'h17, 5'h0e, 3'h2, 4'h1}};
      for (int c = 0; c < 5; c++) begin
         wr(`VIM_REG_PERIOD, 32'(c));
         rchk(`VIM_REG_PERIOD, 32'(c), "period");
         dip();
         wr(`VIM_REG_IRQ_STAT, 32'h7);
         {hour, mday, wday, month} <= st[2 * c];
         repeat (4) @(posedge mclk);
         rchk(`VIM_REG_COUNT, exp_cnt, "count kept");
         {hour, mday, wday, month} <= st[2 * c + 1];
         repeat (4) @(posedge mclk);
         @(negedge mclk);
         `CHK("bound irq", 1'b1, irq)
         rchk(`VIM_REG_PREV_COUNT, exp_cnt, "prev");
         rchk(`VIM_REG_PREV_TOTAL, exp_tot, "prev total");
         rchk(`VIM_REG_COUNT, 32'h0, "count clr");
         rchk(`VIM_REG_TOTAL, 32'h0, "total clr");
         rchk(`VIM_REG_IRQ_STAT, 32'h2, "bound stat");
         wr(`VIM_REG_IRQ_STAT, 32'h7);
         exp_cnt = 0;
         exp_tot = 0;
      end
      $display("test period done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_limit();
      t_dip();
      t_period();
      finish_test();
   end

   // Run needs about 4600 cycles; this is a generous ceiling
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      finish_test();
   end
endmodule

// [tb/vim_checker.sv]
// Port-level assertions for the voltage interruption monitor
`include "vim_defs.vh"

module vim_checker #(
   parameter TICK_CYC = 250000,
   parameter TICK_W = 18
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Measurement
   input wire meas_valid,
   input wire [`VIM_LIM_W-1:0] positive_seq_voltage,
   // Bus handshakes
   input wire s_awvalid,
   input wire s_awready,
   input wire s_wvalid,
   input wire s_wready,
   input wire [1:0] s_bresp,
   input wire s_bvalid,
   input wire s_bready,
   input wire s_arvalid,
   input wire s_arready,
   input wire [31:0] s_rdata,
   input wire [1:0] s_rresp,
   input wire s_rvalid,
   input wire s_rready,
   // Status
   input wire voltage_low,
   input wire irq
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // -----------------------------------------------------------
   // Voltage status
   // -----------------------------------------------------------
   // Below the smallest legal limit is below any limit
   property p_low_set;
      meas_valid && positive_seq_voltage < 11'h064 |-> ##[1:2] voltage_low;
   endproperty
   a_low_set: assert property (p_low_set)
      else $error("status not low after deep sample");
   property p_low_clr;
      meas_valid && positive_seq_voltage >= 11'h4b0 |-> ##[1:2] !voltage_low;
   endproperty
   a_low_clr: assert property (p_low_clr)
      else $error("status not ok after high sample");
   // Status only moves on a sample
   property p_low_hold;
      !meas_valid && !$past(meas_valid) |=> $stable(voltage_low);
   endproperty
   a_low_hold: assert property (p_low_hold)
      else $error("status changed without sample");

   // -----------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------
   property p_b_lat;
      s_awvalid && s_awready && s_wvalid && s_wready |=> !s_bvalid ##1 s_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat)
      else $error("write response latency wrong");
   property p_r_lat;
      s_arvalid && s_arready |=> !s_rvalid ##1 s_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read response latency wrong");
   property p_b_hold;
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_r_hold;
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_busy_w;
      s_bvalid |-> !s_awready && !s_wready;
   endproperty
   a_busy_w: assert property (p_busy_w)
      else $error("write accepted while answer pending");
   property p_busy_r;
      s_rvalid |-> !s_arready;
   endproperty
   a_busy_r: assert property (p_busy_r)
      else $error("read accepted while answer pending");
   property p_err_data;
      s_rvalid && s_rresp == `VIM_RESP_SLVERR |-> s_rdata == 32'h0;
   endproperty
   a_err_data: assert property (p_err_data)
      else $error("error read returned data");

   c_dip: cover property ($rose(voltage_low));
   c_wr: cover property (s_bvalid && s_bready);
   c_rd: cover property (s_rvalid && s_rready);
   c_irq: cover property ($rose(irq));
endmodule

bind vim_top vim_checker #(.TICK_CYC(TICK_CYC), .TICK_W(TICK_W)) u_chk (
   .mclk(mclk), .rst(rst), .meas_valid(meas_valid),
   .positive_seq_voltage(positive_seq_voltage),
   .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
   .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
   .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
   .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
   .s_rready(s_rready), .voltage_low(voltage_low), .irq(irq)
);
